/* maint_params.svh */
`ifndef MAINT_PARAMS_SVH
`define MAINT_PARAMS_SVH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define BANK_COUNT 8
`define BANK_BITS 3
`define ROW_BITS 12
`define ROW_ZERO 12'h000
`define ROW_ONE 12'h001
// ----------------------------------------
// Timing in request clock cycles
// ----------------------------------------
`define T_RAS_CYC 8'h0a
`define T_RP_CYC 8'h06
`define T_RR_CYC 8'h04
`define T_PP_CYC 8'h04
`define T_CMD_CURRENT_CAL_BEGIN_CYC 8'h08
`define T_CALCE_CYC 8'h10
`define T_CAL_FINISH_CMD_CYC 8'h08
`define T_CURRENT_CAL_BEGIN_REPEAT_CYC 24'h00c350
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`define CAL_STEP 4'h1
`define CAL_ZERO 4'h0
`endif

/* maint_pkg.sv */
package maint_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_REF_ACT, OP_REF_ACT_ADV, OP_REF_CLOSE, OP_CAL_CUR, OP_CAL_TERM, OP_CAL_FIN
  } maint_op_t;
  typedef enum {CAL_IDLE, CAL_CUR_RUN, CAL_TERM_RUN} cal_state_t;
endpackage : maint_pkg

/* maint_link_if.sv */
`timescale 1ns/1ps
interface maint_link_if;
  import maint_pkg::*;
  logic req_valid;
  maint_op_t req_op;
  logic [2:0] req_bank;
  logic [1:0] req_delay;
  logic [7:0] bank_open;
  logic cal_busy;
  modport controller (output req_valid, req_op, req_bank, req_delay, input bank_open, cal_busy);
  modport memory (input req_valid, req_op, req_bank, req_delay, output bank_open, cal_busy);
endinterface : maint_link_if

/* maint_memory_end.sv */
`timescale 1ns/1ps
`include "maint_params.svh"
// Functional notes
// - Refresh activate opens bank at pointer row
// - Refresh commands carry bank, delay, pointer row
// - Refresh close shuts bank like precharge
// - Controller waits precharge time before reopening
// - Refreshes to different banks may overlap
// - Refresh always senses the full page
// - Every row refreshed within refresh period
// - Advance variant increments pointer; plain keeps it
// - Burst of eight activations, last advances
// - Eight closes start one active time later
// - Ordinary activations may border the burst
// - Only output current calibration is performed
// - Bus idle before calibration begins
// - Calibration begin then quiet enable interval
// - Calibration finish then quiet interval
// - Next current calibration within repeat interval
// - Termination calibration tolerated, no effect
// - Termination sequence framed by quiet intervals
// - Pointer spans all rows of a bank
module maint_memory_end
  import maint_pkg::*;
#(
  parameter int ROW_BITS = `ROW_BITS
) (
  input wire logic clk,
  input wire logic arst_n,
  maint_link_if.memory link,
  input wire logic [1:0] subpage_select,
  output logic [ROW_BITS-1:0] maintenance_row_pointer,
  output logic sense_valid,
  output logic [2:0] sense_bank,
  output logic [ROW_BITS-1:0] sense_row,
  output logic sense_full_page,
  output logic [3:0] current_cal_count
);
  // Narrower pointers serve short test runs; wider ones exceed the array
  if (ROW_BITS < 1 || ROW_BITS > `ROW_BITS) begin : g_bad_row_bits
    $error("ROW_BITS out of range");
  end

  // ----------------------------------------
  // Bank state and sensing
  // ----------------------------------------
  logic [7:0] open_r;
  logic cal_busy_r;
  cal_state_t cal_r;
  wire logic is_act = link.req_valid &&
    (link.req_op == OP_REF_ACT || link.req_op == OP_REF_ACT_ADV);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      open_r <= 8'h00;
    end else if (link.req_valid) begin
      // Per-bank state lets refreshes to other banks overlap
      if (is_act) open_r[link.req_bank] <= 1'b1;
      else if (link.req_op == OP_REF_CLOSE) open_r[link.req_bank] <= 1'b0;
    end
  end
  assign link.bank_open = open_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sense_valid <= 1'b0;
      sense_bank <= 3'h0;
      sense_row <= ROW_BITS'(`ROW_ZERO);
      sense_full_page <= 1'b0;
    end else begin
      // Only a closed bank is sensed
      sense_valid <= is_act && !open_r[link.req_bank];
      if (is_act) begin
        sense_bank <= link.req_bank;
        sense_row <= maintenance_row_pointer;
        sense_full_page <= 1'b1; // subpage_select ignored
      end
    end
  end

  // ----------------------------------------
  // Row pointer
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      maintenance_row_pointer <= ROW_BITS'(`ROW_ZERO);
    end else if (is_act && link.req_op == OP_REF_ACT_ADV) begin
      // Natural overflow wraps to row zero
      maintenance_row_pointer <= maintenance_row_pointer + ROW_BITS'(`ROW_ONE);
    end
  end

  // ----------------------------------------
  // Calibration
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_r <= CAL_IDLE;
      cal_busy_r <= 1'b0;
      current_cal_count <= `CAL_ZERO;
    end else if (link.req_valid) begin
      case (link.req_op)
        OP_CAL_CUR: begin
          cal_r <= CAL_CUR_RUN;
          cal_busy_r <= 1'b1;
        end
        OP_CAL_TERM: begin
          cal_r <= CAL_TERM_RUN;
          cal_busy_r <= 1'b0;
        end
        OP_CAL_FIN: begin
          // Drive strength step only after a current sequence
          if (cal_r == CAL_CUR_RUN) current_cal_count <= current_cal_count + `CAL_STEP;
          cal_r <= CAL_IDLE;
          cal_busy_r <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end
  assign link.cal_busy = cal_busy_r;
endmodule : maint_memory_end

/* maint_controller_end.sv */
`timescale 1ns/1ps
`include "maint_params.svh"
module maint_controller_end
  import maint_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  maint_link_if.controller link,
  input wire logic refresh_burst_req,
  input wire logic cal_req,
  input wire logic term_cal_req,
  output logic busy,
  output logic cal_overdue
);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum {S_IDLE, S_ACT, S_WAIT_RAS, S_CLOSE, S_WAIT_RP, S_CAL_QUIET, S_CAL_BEGIN,
    S_CAL_RUN, S_CAL_FIN, S_CAL_TAIL} seq_t;
  seq_t st_r;
  logic [7:0] cnt_r;
  logic [2:0] bank_r;
  logic term_r;
  logic vld_r;
  maint_op_t op_r;
  logic [23:0] since_cal_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= S_IDLE;
      cnt_r <= `CNT_ZERO;
      bank_r <= 3'h0;
      term_r <= 1'b0;
      vld_r <= 1'b0;
      op_r <= OP_NONE;
      busy <= 1'b0;
    end else begin
      vld_r <= 1'b0;
      op_r <= OP_NONE;
      if (cnt_r != `CNT_ZERO) cnt_r <= cnt_r - `CNT_ONE;
      case (st_r)
        S_IDLE: begin
          busy <= refresh_burst_req || cal_req || term_cal_req;
          if (cal_req || term_cal_req) begin
            term_r <= !cal_req;
            cnt_r <= `T_CMD_CURRENT_CAL_BEGIN_CYC;
            st_r <= S_CAL_QUIET;
          end else if (refresh_burst_req) begin
            bank_r <= 3'h0;
            st_r <= S_ACT;
          end
        end
        S_ACT: if (cnt_r == `CNT_ZERO) begin
          vld_r <= 1'b1;
          // Last of eight advances the pointer
          op_r <= (bank_r == 3'h7) ? OP_REF_ACT_ADV : OP_REF_ACT;
          cnt_r <= `T_RR_CYC;
          if (bank_r == 3'h7) begin
            bank_r <= 3'h0;
            // Sequential issue: first close waits out whatever active time remains
            cnt_r <= (`T_RAS_CYC > `T_RR_CYC * 8'h07) ?
              `T_RAS_CYC - `T_RR_CYC * 8'h07 : `T_RR_CYC;
            st_r <= S_WAIT_RAS;
          end else bank_r <= bank_r + 3'h1;
        end
        S_WAIT_RAS: if (cnt_r == `CNT_ZERO) st_r <= S_CLOSE;
        S_CLOSE: if (cnt_r == `CNT_ZERO) begin
          vld_r <= 1'b1;
          op_r <= OP_REF_CLOSE;
          cnt_r <= `T_PP_CYC;
          bank_r <= bank_r + 3'h1;
          if (bank_r == 3'h7) begin
            cnt_r <= `T_RP_CYC;
            st_r <= S_WAIT_RP;
          end
        end
        S_WAIT_RP: if (cnt_r == `CNT_ZERO) st_r <= S_IDLE;
        S_CAL_QUIET: if (cnt_r == `CNT_ZERO) st_r <= S_CAL_BEGIN;
        S_CAL_BEGIN: begin
          vld_r <= 1'b1;
          op_r <= term_r ? OP_CAL_TERM : OP_CAL_CUR;
          cnt_r <= `T_CALCE_CYC;
          st_r <= S_CAL_RUN;
        end
        S_CAL_RUN: if (cnt_r == `CNT_ZERO) st_r <= S_CAL_FIN;
        S_CAL_FIN: begin
          vld_r <= 1'b1;
          op_r <= OP_CAL_FIN;
          cnt_r <= `T_CAL_FINISH_CMD_CYC;
          st_r <= S_CAL_TAIL;
        end
        S_CAL_TAIL: if (cnt_r == `CNT_ZERO) st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end
  assign link.req_valid = vld_r;
  assign link.req_op = op_r;
  // Bank presented with op is the one latched before the increment
  logic [2:0] out_bank_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) out_bank_r <= 3'h0;
    else out_bank_r <= bank_r;
  end
  assign link.req_bank = out_bank_r;
  assign link.req_delay = 2'h0;

  // ----------------------------------------
  // Calibration repeat watchdog
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_cal_r <= 24'h000000;
      cal_overdue <= 1'b0;
    end else if (vld_r && op_r == OP_CAL_CUR) begin
      since_cal_r <= 24'h000000;
      cal_overdue <= 1'b0;
    end else begin
      if (since_cal_r != `T_CURRENT_CAL_BEGIN_REPEAT_CYC) since_cal_r <= since_cal_r + 24'h000001;
      cal_overdue <= since_cal_r == `T_CURRENT_CAL_BEGIN_REPEAT_CYC;
    end
  end
endmodule : maint_controller_end

/* maint_link_asserts.sv */
`timescale 1ns/1ps
`include "maint_params.svh"
module maint_link_asserts
  import maint_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire maint_op_t req_op,
  input wire logic [2:0] req_bank,
  input wire logic [1:0] req_delay,
  input wire logic [7:0] bank_open,
  input wire logic cal_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Quiet cycles since last request
  // ----------------------------------------
  // Starts saturated so a first request after reset is never flagged
  logic [7:0] idle_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_r <= 8'hff;
    end else if (req_valid) begin
      idle_r <= 8'h00;
    end else if (idle_r != 8'hff) begin
      idle_r <= idle_r + 8'h01;
    end
  end
  wire logic is_act = req_valid && (req_op == OP_REF_ACT || req_op == OP_REF_ACT_ADV);
  wire logic is_close = req_valid && req_op == OP_REF_CLOSE;
  wire logic is_cal = req_valid && req_op == OP_CAL_CUR;
  wire logic is_fin = req_valid && req_op == OP_CAL_FIN;
  // ----------------------------------------
  // Cycles since each bank was activated
  // ----------------------------------------
  // A counter per bank replaces a long repetition the tools would unroll
  logic [7:0] act_age_r [8];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int b = 0; b < 8; b++) act_age_r[b] <= 8'hff;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (is_act && req_bank == 3'(b)) act_age_r[b] <= 8'h00;
        else if (act_age_r[b] != 8'hff) act_age_r[b] <= act_age_r[b] + 8'h01;
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_act_opens_bank: assert property (is_act && !bank_open[req_bank]
    |=> bank_open[$past(req_bank)]) else $error("activated bank stayed closed");
  a_delay_field_zero: assert property (req_valid |-> req_delay == 2'h0)
    else $error("unexpected delay value");
  a_close_shuts_bank: assert property (is_close |=> !bank_open[$past(req_bank)])
    else $error("closed bank stayed open");
  a_close_not_early: assert property (is_close |-> act_age_r[req_bank] >= `T_RAS_CYC - 8'h01)
    else $error("close before active time");
  a_act_row_spacing: assert property (is_act |=> !is_act [*3])
    else $error("activations too close");
  a_quiet_before_cal: assert property (is_cal |-> idle_r >= 8'h08)
    else $error("bus busy before calibration");
  a_cal_enable_quiet: assert property (is_cal
    |=> !req_valid [*8] ##1 !req_valid [*8] ##[1:8] is_fin) else $error("bad calibration window");
  a_cal_busy_on: assert property (is_cal |=> cal_busy [*8])
    else $error("calibration not running");
  a_fin_quiet_end: assert property (is_fin |=> !cal_busy && !req_valid [*8])
    else $error("no quiet after finish");
  a_term_no_effect: assert property (req_valid && req_op == OP_CAL_TERM && !cal_busy
    |=> !cal_busy && $stable(bank_open)) else $error("termination calibration acted");
  c_burst_adv: cover property (req_valid && req_op == OP_REF_ACT_ADV);
  c_cal_cur: cover property (is_cal);
  c_cal_term: cover property (req_valid && req_op == OP_CAL_TERM);
endmodule : maint_link_asserts

/* dram_refresh_calibration_ops_tb_top.sv */
`timescale 1ns/1ps
module dram_refresh_calibration_ops_tb_top;
  // Short pointer so the wrap is reached in a few bursts
  localparam int RB = 3;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic burst_req = 1'b0;
  logic cal_req = 1'b0;
  logic term_req = 1'b0;
  logic [1:0] subpage = 2'h3;
  logic busy, cal_overdue, sense_valid, full_page;
  logic [2:0] sense_bank;
  logic [RB-1:0] ptr, sense_row;
  logic [RB-1:0] exp_row = '0;
  logic [3:0] cal_count;
  int failures = 0;
  int n_compared = 0;
  int n_sense = 0;
  int cycles = 0;
  maint_link_if i_maint_link_if ();
  maint_controller_end i_maint_controller_end (.clk(clk), .arst_n(arst_n),
    .link(i_maint_link_if.controller), .refresh_burst_req(burst_req), .cal_req(cal_req),
    .term_cal_req(term_req), .busy(busy), .cal_overdue(cal_overdue));
  maint_memory_end #(.ROW_BITS(RB)) i_maint_memory_end (.clk(clk), .arst_n(arst_n),
    .link(i_maint_link_if.memory), .subpage_select(subpage), .maintenance_row_pointer(ptr),
    .sense_valid(sense_valid), .sense_bank(sense_bank), .sense_row(sense_row),
    .sense_full_page(full_page), .current_cal_count(cal_count));
  maint_link_asserts i_maint_link_asserts (.clk(clk), .arst_n(arst_n),
    .req_valid(i_maint_link_if.req_valid), .req_op(i_maint_link_if.req_op),
    .req_bank(i_maint_link_if.req_bank), .req_delay(i_maint_link_if.req_delay),
    .bank_open(i_maint_link_if.bank_open), .cal_busy(i_maint_link_if.cal_busy));
  initial begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // Request held until taken, then bounded wait for idle
  task automatic run_op(input logic [2:0] sel);
    int n;
    n = 0;
    {term_req, cal_req, burst_req} = sel;
    while (busy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    {term_req, cal_req, burst_req} = 3'h0;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(busy, 1'b0);
  endtask : run_op
  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(negedge clk) begin
    if (sense_valid === 1'b1) begin
      n_sense++;
      check(sense_row, exp_row);
      check(full_page, 1'b1);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    check(ptr, 0);
    check(i_maint_link_if.bank_open, 0);
    for (int i = 0; i < 9; i++) begin
      subpage = 2'(i);
      run_op(3'h1);
      check(n_sense, 8 * (i + 1));
      exp_row++;
      check(ptr, exp_row);
      check(i_maint_link_if.bank_open, 0);
    end
    run_op(3'h2);
    check(cal_count, 1);
    check(ptr, exp_row);
    run_op(3'h4);
    check(cal_count, 1);
    run_op(3'h6);
    check(cal_count, 2);
    run_op(3'h1);
    check(n_sense, 80);
    check(cal_overdue, 1'b0);
    complete_run();
  end
endmodule : dram_refresh_calibration_ops_tb_top
